// ===== codec_output_input_config_regs.sv
`timescale 1ns/10ps
`include "codec_cfg.svh"
// What this block does
// - mode bit picks differential or single-ended outputs
// - first output mute bit silences first output
// - second output mute bit silences second output
// - driver field enables none, first or second
// - source field routes one of four ADC inputs
// - gain register reads cycle through four sub-registers
module codec_output_input_config_regs
#(
  // arbitrary value
  parameter logic [2:0] CHIP_VERSION = 3'h1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic output_mode_select_o,
  output logic first_output_silence_o,
  output logic second_output_silence_o,
  output logic first_analog_output_en_o,
  output logic second_analog_output_en_o,
  output logic [3:0] adc_source_select_o
);

  reg_access_if ra();
  codec_types_pkg::bank_state_t b_r;
  codec_types_pkg::bank_state_t b_nxt;
  codec_types_pkg::analog_ctrl_t ctrl;

  wb_slave u_slave
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .ra(ra.slave)
  );

  function automatic logic [7:0] sub_read(
    input codec_types_pkg::bank_state_t b);
    case (b.rd_ptr)
      `SUB_ADC_GAIN: sub_read = {`SUB_ADC_GAIN, b.adc_gain};
      `SUB_DAC_GAIN: sub_read = {`SUB_DAC_GAIN, b.dac_gain};
      `SUB_SIDETONE: sub_read = {`SUB_SIDETONE, b.stg, 1'b0, b.inbg};
      default: sub_read = {`SUB_IDENT, 3'h0, CHIP_VERSION};
    endcase
  endfunction

  assign ra.hit = (ra.idx == `REG_GAIN_IDX) || (ra.idx == `REG_OCFG_IDX);

  always_comb
  begin
    ra.rdata = 8'h00;
    if (ra.idx == `REG_GAIN_IDX)
      ra.rdata = sub_read(b_r);
    else if (ra.idx == `REG_OCFG_IDX)
      ra.rdata = {b_r.ocfg, 1'b0};
  end

  always_comb
  begin
    b_nxt = b_r;
    if (ra.req && ra.idx == `REG_GAIN_IDX)
    begin
      if (!ra.we)
        b_nxt.rd_ptr = 2'(b_r.rd_ptr + 2'h1);
      else
      begin
        case (ra.wdata[`SUB_TAG_HI:`SUB_TAG_LO])
          `SUB_ADC_GAIN: b_nxt.adc_gain = ra.wdata[5:0];
          `SUB_DAC_GAIN: b_nxt.dac_gain = ra.wdata[5:0];
          `SUB_SIDETONE:
          begin
            b_nxt.stg = ra.wdata[`STG_HI:`STG_LO];
            b_nxt.inbg = ra.wdata[`INBG_HI:`INBG_LO];
          end
          // identification holds nothing writable
          default: b_nxt.rd_ptr = b_r.rd_ptr;
        endcase
      end
    end
    else if (ra.req && ra.we && ra.idx == `REG_OCFG_IDX)
    begin
      b_nxt.ocfg.mode = ra.wdata[`OCFG_MODE_BIT];
      b_nxt.ocfg.mute1 = ra.wdata[`OCFG_MUTE1_BIT];
      b_nxt.ocfg.first_output_silence = ra.wdata[`OCFG_FIRST_OUTPUT_SILENCE_BIT];
      b_nxt.ocfg.drv = ra.wdata[`OCFG_DRV_HI:`OCFG_DRV_LO];
      b_nxt.ocfg.src = ra.wdata[`OCFG_SRC_HI:`OCFG_SRC_LO];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      b_r <= '{adc_gain: `GAIN_RST, dac_gain: `GAIN_RST, stg: `STG_RST,
               inbg: `INBG_RST, rd_ptr: 2'h0, ocfg: `OCFG_RST};
    else
      b_r <= b_nxt;
  end

  analog_ctrl_decode u_decode
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_i(b_r.ocfg),
    .ctrl_o(ctrl)
  );

  assign output_mode_select_o = ctrl.single_ended;
  assign first_output_silence_o = ctrl.first_mute;
  assign second_output_silence_o = ctrl.second_mute;
  assign first_analog_output_en_o = ctrl.first_en;
  assign second_analog_output_en_o = ctrl.second_en;
  assign adc_source_select_o = ctrl.src_onehot;
endmodule

// ===== codec_cfg.svh
`ifndef CODEC_CFG_SVH
`define CODEC_CFG_SVH

// word indices; byte address is four times the index
`define REG_GAIN_IDX 3'h5
`define REG_OCFG_IDX 3'h6
`define ADR_IDX_HI 4
`define ADR_IDX_LO 2

// sub-register tag in bits 7..6 of the shared gain register
`define SUB_TAG_HI 7
`define SUB_TAG_LO 6
`define SUB_ADC_GAIN 2'h0
`define SUB_DAC_GAIN 2'h1
`define SUB_SIDETONE 2'h2
`define SUB_IDENT 2'h3

// sidetone sub-register fields
`define STG_HI 5
`define STG_LO 3
`define INBG_HI 1
`define INBG_LO 0

// output/input configuration register fields
`define OCFG_MODE_BIT 7
`define OCFG_MUTE1_BIT 6
`define OCFG_FIRST_OUTPUT_SILENCE_BIT 5
`define OCFG_DRV_HI 4
`define OCFG_DRV_LO 3
`define OCFG_SRC_HI 2
`define OCFG_SRC_LO 1

// reset values
`define OCFG_RST 7'h00
`define GAIN_RST 6'h2A
`define STG_RST 3'h7
`define INBG_RST 2'h0

// driver field codes
`define DRV_OFF 2'h0
`define DRV_FIRST 2'h1
`define DRV_SECOND 2'h2
`define DRV_SECOND_ALT 2'h3

`endif

// ===== codec_types_pkg.sv
package codec_types_pkg;

  typedef enum logic [0:0]
  {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  typedef struct packed
  {
    logic mode;
    logic mute1;
    logic first_output_silence;
    logic [1:0] drv;
    logic [1:0] src;
  } out_cfg_t;

  typedef struct packed
  {
    bus_state_t st;
    logic [7:0] dat;
  } slave_state_t;

  typedef struct packed
  {
    logic [5:0] adc_gain;
    logic [5:0] dac_gain;
    logic [2:0] stg;
    logic [1:0] inbg;
    logic [1:0] rd_ptr;
    out_cfg_t ocfg;
  } bank_state_t;

  typedef struct packed
  {
    logic single_ended;
    logic first_mute;
    logic second_mute;
    logic first_en;
    logic second_en;
    logic [3:0] src_onehot;
  } analog_ctrl_t;

endpackage

// ===== reg_access_if.sv
`timescale 1ns/10ps
interface reg_access_if;
  logic req;
  logic we;
  logic hit;
  logic [2:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave
  (
    output req,
    output we,
    output idx,
    output wdata,
    input hit,
    input rdata
  );

  modport bank
  (
    input req,
    input we,
    input idx,
    input wdata,
    output hit,
    output rdata
  );
endinterface

// ===== wb_slave.sv
`timescale 1ns/10ps
`include "codec_cfg.svh"
module wb_slave
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  reg_access_if.slave ra
);

  codec_types_pkg::slave_state_t s_r;
  codec_types_pkg::slave_state_t s_nxt;

  // word aligned and inside the small decoded window
  function automatic logic adr_ok(input logic [7:0] a);
    adr_ok = (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
  endfunction

  // one request pulse per cycle; ack blocks a repeat of the same access;
  // a write without byte lane 0 is no request at all, so it cannot move
  // the gain read pointer as a read would
  assign ra.req = cyc_i && stb_i && (s_r.st == codec_types_pkg::BUS_IDLE)
    && adr_ok(adr_i) && (!we_i || sel_i[0]);
  assign ra.we = we_i;
  assign ra.idx = adr_i[`ADR_IDX_HI:`ADR_IDX_LO];
  assign ra.wdata = dat_i[7:0];

  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      codec_types_pkg::BUS_IDLE:
      begin
        if (cyc_i && stb_i)
        begin
          s_nxt.st = codec_types_pkg::BUS_ACK;
          // unmapped or write: read data is zero
          s_nxt.dat = (ra.req && ra.hit && !we_i) ? ra.rdata : 8'h00;
        end
      end
      codec_types_pkg::BUS_ACK:
        s_nxt.st = codec_types_pkg::BUS_IDLE;
      default:
        s_nxt.st = codec_types_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_r <= '{st: codec_types_pkg::BUS_IDLE, dat: 8'h00};
    else
      s_r <= s_nxt;
  end

  assign ack_o = (s_r.st == codec_types_pkg::BUS_ACK);
  assign dat_o = {24'h000000, s_r.dat};
endmodule

// ===== analog_ctrl_decode.sv
`timescale 1ns/10ps
`include "codec_cfg.svh"
module analog_ctrl_decode
(
  input wire logic clk_i,
  input wire logic rst_i,
  input codec_types_pkg::out_cfg_t cfg_i,
  output codec_types_pkg::analog_ctrl_t ctrl_o
);

  codec_types_pkg::analog_ctrl_t c_r;
  codec_types_pkg::analog_ctrl_t c_nxt;

  always_comb
  begin
    c_nxt = c_r;
    c_nxt.single_ended = cfg_i.mode;
    c_nxt.first_mute = cfg_i.mute1;
    c_nxt.second_mute = cfg_i.first_output_silence;
    case (cfg_i.drv)
      `DRV_OFF:
      begin
        c_nxt.first_en = 1'b0;
        c_nxt.second_en = 1'b0;
      end
      `DRV_FIRST:
      begin
        c_nxt.first_en = 1'b1;
        c_nxt.second_en = 1'b0;
      end
      // code 3 kept identical to code 2 as printed
      default:
      begin
        c_nxt.first_en = 1'b0;
        c_nxt.second_en = 1'b1;
      end
    endcase
    c_nxt.src_onehot = 4'h1 << cfg_i.src;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      c_r <= '{single_ended: 1'b0, first_mute: 1'b0, second_mute: 1'b0,
               first_en: 1'b0, second_en: 1'b0, src_onehot: 4'h1};
    else
      c_r <= c_nxt;
  end

  assign ctrl_o = c_r;
endmodule

// ===== cfg_asserts.sv
`timescale 1ns/10ps
module cfg_asserts
(
  input logic clk_i,
  input logic rst_i,
  input logic cyc_i,
  input logic stb_i,
  input logic we_i,
  input logic [7:0] adr_i,
  input logic [3:0] sel_i,
  input logic [31:0] dat_i,
  input logic [31:0] dat_o,
  input logic ack_o,
  input logic output_mode_select_o,
  input logic first_output_silence_o,
  input logic second_output_silence_o,
  input logic first_analog_output_en_o,
  input logic second_analog_output_en_o,
  input logic [3:0] adc_source_select_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic req;
  logic [1:0] rd_cnt_r;
  assign req = cyc_i & stb_i & ~ack_o;
  // shadow of the read pointer: only gain reads move it
  always_ff @(posedge clk_i)
    if (rst_i)
      rd_cnt_r <= 2'h0;
    else if (req && !we_i && adr_i == 8'h14)
      rd_cnt_r <= rd_cnt_r + 2'h1;
  sequence s_wr;
    req && we_i && sel_i[0] && adr_i == 8'h18 ##1 ack_o;
  endsequence
  sequence s_rd(a);
    req && !we_i && adr_i == a ##1 ack_o;
  endsequence
  a_mode_write:
    assert property (s_wr |=> output_mode_select_o == $past(dat_i[7], 2))
      else $error("mode bit wrong");
  a_first_mute:
    assert property (s_wr |=> first_output_silence_o == $past(dat_i[6], 2))
      else $error("first mute wrong");
  a_second_mute:
    assert property (s_wr |=> second_output_silence_o == $past(dat_i[5], 2))
      else $error("second mute wrong");
  a_driver_decode:
    assert property (s_wr |=> second_analog_output_en_o == $past(dat_i[4], 2)
      && first_analog_output_en_o == ($past(dat_i[4:3], 2) == 2'h1))
      else $error("driver enables wrong");
  a_source_onehot:
    assert property (s_wr |=>
      adc_source_select_o == 4'h1 << $past(dat_i[2:1], 2))
      else $error("source select wrong");
  a_gain_order:
    assert property (s_rd(8'h14) |-> dat_o[7:6] == $past(rd_cnt_r))
      else $error("sub-register order wrong");
  a_cfg_reserved:
    assert property (s_rd(8'h18) |-> dat_o[0] == 1'b0 && dat_o[31:8] == 24'h0)
      else $error("reserved bits not zero");
endmodule
bind codec_output_input_config_regs cfg_asserts u_cfg_asserts (.*);

// ===== test_codec_output_input_config_regs.sv
`timescale 1ns/10ps
module test_codec_output_input_config_regs;
  localparam logic [2:0] VER = 3'h5; // arbitrary version code
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00, cfg, gain[4];
  logic [3:0] sel_i = 4'h0, adc_source_select_o;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, output_mode_select_o, first_output_silence_o;
  logic second_output_silence_o, first_analog_output_en_o;
  logic second_analog_output_en_o;
  int num_errors = 0, checks_done = 0, cycles = 0, ptr;
  codec_output_input_config_regs #(.CHIP_VERSION(VER))
    u_codec_output_input_config_regs (.*);
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic init();
    cfg = 8'h00;
    gain = '{8'h2A, 8'h6A, 8'hB8, {5'h18, VER}};
    ptr = 0;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d,
    input logic [3:0] s);
    logic [7:0] e;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'($urandom), d};
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (w && s[0] && a == 8'h18)
      cfg = d & 8'hFE;
    else if (w && s[0] && a == 8'h14 && d[7:6] != 2'h3)
      gain[d[7:6]] = d[7:6] == 2'h2 ? d & 8'hFB : d;
    else if (!w)
    begin
      e = a == 8'h18 ? cfg : a == 8'h14 ? gain[ptr] : 8'h00;
      chk(dat_o, {24'h000000, e});
      ptr = a == 8'h14 ? (ptr + 1) % 4 : ptr;
    end
  endtask
  task automatic chk_out();
    logic [8:0] seen, exp;
    @(posedge clk_i);
    seen = {output_mode_select_o, first_output_silence_o,
      second_output_silence_o, first_analog_output_en_o,
      second_analog_output_en_o, adc_source_select_o};
    exp = {cfg[7:5], cfg[4:3] == 2'h1, cfg[4], 4'h1 << cfg[2:1]};
    chk({23'h000000, seen}, {23'h000000, exp});
  endtask
  initial
  begin
    void'($urandom(32'h74F113B3));
    init();
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_out();
    acc(1'b0, 8'h18, 8'h00, 4'hF);
    repeat (5) acc(1'b0, 8'h14, 8'h00, 4'hF);
    $display("reset values done");
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, 8'h18, {3'($urandom), 4'(i), 1'($urandom)}, 4'hF);
      chk_out();
      acc(1'b0, 8'h18, 8'h00, 4'hF);
    end
    $display("config codes done");
    acc(1'b1, 8'h18, 8'h00, 4'hE);
    acc(1'b1, 8'h98, 8'hFF, 4'hF);
    acc(1'b0, 8'h98, 8'h00, 4'hF);
    acc(1'b0, 8'h18, 8'h00, 4'hF);
    chk_out();
    // a lane-less write to the gain register must not move the pointer
    acc(1'b1, 8'h14, 8'h00, 4'hE);
    $display("refused writes done");
    acc(1'b1, 8'h14, 8'h15, 4'hF);
    acc(1'b1, 8'h14, 8'h55, 4'hF);
    acc(1'b1, 8'h14, 8'hBF, 4'hF);
    acc(1'b1, 8'h14, 8'hFF, 4'hF);
    repeat (4) acc(1'b0, 8'h14, 8'h00, 4'hF);
    $display("gain reads done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    init();
    chk_out();
    repeat (4) acc(1'b0, 8'h14, 8'h00, 4'hF);
    $display("second reset done");
    give_verdict();
  end
endmodule
